// [core/pssf_flags.sv]
/*
  Special status flags of a controller CPU: startup, constant,
  timebase, alternate scan, mode, break, interrupt, freeze, switch
  mirror, scan overrun, battery and I/O configuration flags.
  Assumes all inputs are synchronous to clk; scan_start pulses once
  at the start of every program scan.
*/
// Summary of operation
// - First-pass flag is on during the first scan after power or after entry to run from program.
// - First-pass flag clears at the second scan and stays off until the next program-to-run entry.
// - Constant-true flag always reads one.
// - Constant-false flag always reads zero.
// - Minute timebase: 30 s high, 30 s low, forever.
// - Second timebase: 0.5 s high, 0.5 s low.
// - Tenth-second timebase: 50 ms high, 50 ms low.
// - Twentieth-second timebase: 25 ms high, 25 ms low.
// - Alternating-pass flag inverts at every scan start.
// - Forced-run flag follows keyswitch in run position.
// - Terminal-run flag: keyswitch at terminal and mode is run.
// - Terminal-program flag: keyswitch at terminal and mode is program.
// - Test-run and test-program flags follow the test modes.
// - Forced-stop flag follows keyswitch in stop position.
// - Break flag one sets on break, clears on any mode change.
// - Break flag two sets on break, clears only on entry to run.
// - Interrupt-enabled flag sets on the interrupt enable instruction.
// - Freeze bit holds all I/O; selective bit holds missing-block slots.
// - Four rear switches are mirrored continuously.
// - Scan overrun sets when scan exceeds limit in fixed or limit mode.
// - Low battery on either battery, with a detailed code word.
// - I/O configuration error works only with the check enabled.
`timescale 1ns/1ps

module pssf_flags
  import pssf_pkg::*;
#(
  parameter int TICK_CYCLES = pssf_pkg::TICK_CYC,
  parameter int MS_CYCLES   = pssf_pkg::MS_CYC,
  parameter int SLOTS       = 8
)
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Scan and mode state
  input  wire logic                      scan_start,
  input  wire pssf_pkg::pssf_cpu_mode_t  cpu_mode,
  input  wire pssf_pkg::pssf_key_t       keyswitch,
  // Instruction events
  input  wire logic                      break_exec,
  input  wire logic                      interrupt_enable_instruction,
  input  wire logic                      interrupt_disable_exec,
  // Freeze control and terminal block sense
  input  wire logic                      io_freeze_bit,
  input  wire logic                      selective_freeze_bit,
  input  wire logic [SLOTS-1:0]          block_missing,
  // Rear switches
  input  wire logic [3:0]                rear_switch,
  // Scan time control
  input  wire pssf_pkg::pssf_scan_mode_t scan_mode,
  input  wire logic [15:0]               scan_limit_ms,
  input  wire logic                      overrun_clear,
  // Error sources
  input  wire logic                      cpu_battery_low,
  input  wire logic                      cart_battery_low,
  input  wire logic                      io_config_check_en,
  input  wire logic                      io_config_mismatch,
  // Startup, constant, alternate pass and timebase flags
  output logic                           first_pass_flag,
  output logic                           constant_true_flag,
  output logic                           constant_false_flag,
  output logic                           alternating_pass_flag,
  output pssf_pkg::pssf_timebase_t       timebase,
  // Mode and event flags
  output pssf_pkg::pssf_mode_flags_t     mode_flags,
  output logic                           break_flag_one,
  output logic                           break_flag_two,
  output logic                           interrupt_enabled_flag,
  // I/O freeze controls
  output logic                           io_update_hold,
  output logic [SLOTS-1:0]               slot_output_hold,
  // Mirrors and errors
  output pssf_pkg::pssf_switch_t         switch_mirror,
  output logic                           cpu_battery_disabled_flag,
  output logic                           scan_overrun_flag,
  output logic                           low_battery_flag,
  output logic [15:0]                    battery_error_code_word,
  output logic                           io_config_error_flag
);

  // ==========================================================
  // Parameter checks
  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam int MSP_W = $clog2(MS_CYCLES);

  if (TICK_CYCLES < 2 || MS_CYCLES < 2 || SLOTS < 1)
  begin
    $error("pssf_flags: parameter out of range");
  end

  // Phase of a symmetric square wave at a tick index
  function automatic logic phase_hi(input logic [IDX_W-1:0] idx,
                                    input int half);
    phase_hi = (int'(idx) % (2 * half)) < half;
  endfunction

  // ==========================================================
  // Timebase counter
  logic [PRE_W-1:0] pre_r;
  logic [IDX_W-1:0] idx_r;
  logic             tick;
  logic [IDX_W-1:0] idx_nxt;
  pssf_timebase_t   tb_nxt;
  // Tick decode and wave phases
  assign tick    = (pre_r == PRE_W'(TICK_CYCLES - 1));
  assign idx_nxt = (idx_r == IDX_W'(TICK_WRAP - 1)) ? '0 : idx_r + 1'b1;
  assign tb_nxt.minute_timebase_flag           = phase_hi(idx_r, HALF_1M_TK);
  assign tb_nxt.second_timebase_flag           = phase_hi(idx_r, HALF_1S_TK);
  assign tb_nxt.tenth_second_timebase_flag     = phase_hi(idx_r, HALF_10_TK);
  assign tb_nxt.twentieth_second_timebase_flag = phase_hi(idx_r, HALF_20_TK);
  // Free-running prescaler and tick index
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pre_r <= '0;
      idx_r <= '0;
    end
    else
    begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
      if (tick)
        idx_r <= idx_nxt;
    end
  end

  // Timebase flags registered
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      timebase <= '0;
    else
      timebase <= tb_nxt;
  end

  // ==========================================================
  // Scan flags
  logic        arm_r;
  pssf_cpu_mode_t mode_r;
  logic        to_run;
  logic        prog_to_run;
  logic        mode_change;
  // Mode transition decode
  assign mode_change = (mode_r != cpu_mode);
  assign to_run      = mode_change && (cpu_mode == PSSF_RUN);
  assign prog_to_run = to_run && (mode_r == PSSF_PROGRAM);
  // First pass, alternate pass, constants
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      arm_r                 <= FIRST_ARM_RST;
      first_pass_flag       <= FIRST_PASS_RST;
      alternating_pass_flag <= ALT_PASS_RST;
      constant_true_flag    <= CONST_TRUE_VAL;
      constant_false_flag   <= CONST_FALSE_VAL;
      mode_r                <= PSSF_PROGRAM;
    end
    else
    begin
      mode_r <= cpu_mode;
      if (prog_to_run)
      begin
        arm_r           <= 1'b1;
        first_pass_flag <= 1'b0;
      end
      else if (scan_start)
      begin
        arm_r           <= 1'b0;
        first_pass_flag <= arm_r;
      end
      if (scan_start)
        alternating_pass_flag <= ~alternating_pass_flag;
    end
  end

  // ==========================================================
  // Mode flags
  pssf_mode_flags_t mf_nxt;
  // Keyswitch and mode decode
  assign mf_nxt.forced_run_flag       = (keyswitch == PSSF_KEY_RUN);
  assign mf_nxt.forced_stop_flag      = (keyswitch == PSSF_KEY_STOP);
  assign mf_nxt.terminal_run_flag     = (keyswitch == PSSF_KEY_TERM) &&
                                        (cpu_mode == PSSF_RUN);
  assign mf_nxt.terminal_program_flag = (keyswitch == PSSF_KEY_TERM) &&
                                        (cpu_mode == PSSF_PROGRAM);
  assign mf_nxt.test_run_flag         = (cpu_mode == PSSF_TEST_RUN);
  assign mf_nxt.test_program_flag     = (cpu_mode == PSSF_TEST_PROGRAM);
  // Mode flags registered
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mode_flags <= '0;
    else
      mode_flags <= mf_nxt;
  end

  // ==========================================================
  // Break and interrupt flags, set wins over clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      break_flag_one         <= 1'b0;
      break_flag_two         <= 1'b0;
      interrupt_enabled_flag <= 1'b0;
    end
    else
    begin
      break_flag_one <= break_exec | (break_flag_one & ~mode_change);
      break_flag_two <= break_exec | (break_flag_two & ~to_run);
      interrupt_enabled_flag <= interrupt_enable_instruction |
        (interrupt_enabled_flag & ~interrupt_disable_exec);
    end
  end

  // ==========================================================
  // I/O freeze and switch mirrors
  logic [SLOTS-1:0] hold_nxt;
  // Whole freeze or selective per-slot freeze
  assign hold_nxt = {SLOTS{io_freeze_bit}} |
                    ({SLOTS{selective_freeze_bit}} & block_missing);
  // Freeze and mirror registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      io_update_hold            <= 1'b0;
      slot_output_hold          <= '0;
      switch_mirror             <= '0;
      cpu_battery_disabled_flag <= 1'b0;
    end
    else
    begin
      io_update_hold            <= io_freeze_bit;
      slot_output_hold          <= hold_nxt;
      switch_mirror             <= rear_switch;
      cpu_battery_disabled_flag <= rear_switch[0];
    end
  end

  // ==========================================================
  // Scan time measurement
  logic [MSP_W-1:0]     ms_pre_r;
  logic [SCAN_MS_W-1:0] scan_ms_r;
  logic                 ms_tick;
  logic                 scan_ms_full;
  logic                 overrun_hit;
  // Millisecond tick and overrun compare
  assign ms_tick      = (ms_pre_r == MSP_W'(MS_CYCLES - 1));
  assign scan_ms_full = &scan_ms_r;
  assign overrun_hit  = (scan_mode != PSSF_SCAN_VARIABLE) &&
                        (scan_ms_r > scan_limit_ms);
  // Scan timer restarts at every scan start
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ms_pre_r  <= '0;
      scan_ms_r <= '0;
    end
    else if (scan_start)
    begin
      ms_pre_r  <= '0;
      scan_ms_r <= '0;
    end
    else
    begin
      ms_pre_r <= ms_tick ? '0 : ms_pre_r + 1'b1;
      if (ms_tick && !scan_ms_full)
        scan_ms_r <= scan_ms_r + 1'b1;
    end
  end

  // Sticky overrun flag, set wins over clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      scan_overrun_flag <= 1'b0;
    else
      scan_overrun_flag <= overrun_hit |
                           (scan_overrun_flag & ~overrun_clear);
  end

  // ==========================================================
  // Battery and configuration errors
  logic [15:0] batt_code_nxt;
  // Battery code select
  assign batt_code_nxt = (cpu_battery_low && cart_battery_low) ?
                         BATT_CODE_BOTH :
                         cpu_battery_low  ? BATT_CODE_CPU  :
                         cart_battery_low ? BATT_CODE_CART : BATT_CODE_NONE;
  // Error registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      low_battery_flag        <= 1'b0;
      battery_error_code_word <= BATT_CODE_NONE;
      io_config_error_flag    <= 1'b0;
    end
    else
    begin
      low_battery_flag        <= cpu_battery_low | cart_battery_low;
      battery_error_code_word <= batt_code_nxt;
      io_config_error_flag    <= io_config_check_en &
                                 (io_config_mismatch | io_config_error_flag);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  first_on_a: assert property (scan_start && arm_r && !prog_to_run
    |=> first_pass_flag) else $error("first pass not set");
  first_off_a: assert property (scan_start && !arm_r && !prog_to_run
    |=> !first_pass_flag) else $error("first pass not cleared");
  const_true_a: assert property (constant_true_flag)
    else $error("constant true low");
  const_false_a: assert property (!constant_false_flag)
    else $error("constant false high");
  wave_min_a: assert property ($changed(timebase.minute_timebase_flag)
    |-> ($past(tick, 2) || $past(reset, 2)) && $past(idx_r) % HALF_1M_TK == 0)
    else $error("minute wave off phase");
  wave_sec_a: assert property ($changed(timebase.second_timebase_flag)
    |-> $past(idx_r) % HALF_1S_TK == 0)
    else $error("second wave off phase");
  wave_tenth_a: assert property ($changed(timebase.tenth_second_timebase_flag)
    |-> $past(idx_r) % HALF_10_TK == 0)
    else $error("tenth wave off phase");
  wave_twenty_a: assert property (tick |=> ##1
    $changed(timebase.twentieth_second_timebase_flag))
    else $error("twentieth wave stuck");
  alt_flip_a: assert property (scan_start
    |=> alternating_pass_flag != $past(alternating_pass_flag))
    else $error("alternate pass not toggled");
  key_run_a: assert property (keyswitch == PSSF_KEY_RUN
    |=> mode_flags.forced_run_flag && !mode_flags.forced_stop_flag)
    else $error("forced run wrong");
  term_mode_a: assert property (keyswitch == PSSF_KEY_TERM
    |=> mode_flags.terminal_run_flag == ($past(cpu_mode) == PSSF_RUN))
    else $error("terminal run wrong");
  break_two_a: assert property (break_exec |=> break_flag_two [*1]
    ##0 break_flag_one) else $error("break flags not set");
  overrun_set_a: assert property (overrun_hit |=> scan_overrun_flag)
    else $error("overrun not flagged");
  battery_low_a: assert property (cpu_battery_low || cart_battery_low
    |=> low_battery_flag && battery_error_code_word != BATT_CODE_NONE)
    else $error("battery low missed");
  cfg_gate_a: assert property (!io_config_check_en |=> !io_config_error_flag)
    else $error("config error without check");
  first_scan_c: cover property (scan_start && arm_r ##1 first_pass_flag);
  break_run_c: cover property (break_flag_two ##1 to_run);
  overrun_c: cover property ($rose(scan_overrun_flag));
  freeze_c: cover property (selective_freeze_bit && |block_missing);

endmodule

// [common/pssf_pkg.sv]
/*
  Package for the special status flag block: timing constants, reset
  values, error codes, mode enumerations and flag carrier structs.
  Assumes a 250 MHz system clock.
*/
package pssf_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_MS_NS       = 1000000;
  localparam int MS_CYC        = T_MS_NS / CLK_PERIOD_NS;
  localparam int TB_BASE_MS    = 25;
  localparam int TICK_CYC      = TB_BASE_MS * MS_CYC;
  localparam int HALF_20_MS    = 25;
  localparam int HALF_10_MS    = 50;
  localparam int HALF_1S_MS    = 500;
  localparam int HALF_1M_MS    = 30000;
  localparam int HALF_20_TK    = HALF_20_MS / TB_BASE_MS;
  localparam int HALF_10_TK    = HALF_10_MS / TB_BASE_MS;
  localparam int HALF_1S_TK    = HALF_1S_MS / TB_BASE_MS;
  localparam int HALF_1M_TK    = HALF_1M_MS / TB_BASE_MS;
  localparam int TICK_WRAP     = 2 * HALF_1M_TK;
  localparam int IDX_W         = 12;
  localparam int SCAN_MS_W     = 16;
  localparam int SW_CNT        = 4;

  // ==========================================================
  // Reset values
  localparam logic FIRST_ARM_RST  = 1'b1;
  localparam logic FIRST_PASS_RST = 1'b0;
  localparam logic ALT_PASS_RST   = 1'b0;
  localparam logic CONST_TRUE_VAL = 1'b1;
  localparam logic CONST_FALSE_VAL = 1'b0;

  // ==========================================================
  // Battery error codes (values arbitrary)
  localparam logic [15:0] BATT_CODE_NONE = 16'h0000;
  localparam logic [15:0] BATT_CODE_CPU  = 16'h0001;
  localparam logic [15:0] BATT_CODE_CART = 16'h0002;
  localparam logic [15:0] BATT_CODE_BOTH = 16'h0003;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    PSSF_PROGRAM, PSSF_RUN, PSSF_TEST_PROGRAM, PSSF_TEST_RUN
  } pssf_cpu_mode_t;

  typedef enum logic [1:0] {
    PSSF_KEY_STOP, PSSF_KEY_TERM, PSSF_KEY_RUN
  } pssf_key_t;

  typedef enum logic [1:0] {
    PSSF_SCAN_VARIABLE, PSSF_SCAN_FIXED, PSSF_SCAN_LIMIT
  } pssf_scan_mode_t;

  // ==========================================================
  // Flag carriers
  typedef struct packed {
    logic minute_timebase_flag;
    logic second_timebase_flag;
    logic tenth_second_timebase_flag;
    logic twentieth_second_timebase_flag;
  } pssf_timebase_t;

  typedef struct packed {
    logic forced_run_flag;
    logic terminal_run_flag;
    logic terminal_program_flag;
    logic test_run_flag;
    logic test_program_flag;
    logic forced_stop_flag;
  } pssf_mode_flags_t;

  typedef struct packed {
    logic switch_four_mirror;
    logic switch_three_mirror;
    logic switch_two_mirror;
    logic switch_one_mirror;
  } pssf_switch_t;

endpackage

// [tb/pssf_flags_bench.sv]
/*
  Self-checking bench for the special status flag block.
  Assumes a 250 MHz clock, short timebase and millisecond counts set
  by parameter, and inputs driven by the bench on the falling edge.
*/
`timescale 1ns/1ps

module pssf_flags_bench;
  import pssf_pkg::*;

  // ==========================================================
  // Signals
  localparam int TK = 10;
  localparam int MS = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scan_start = 1'b0;
  pssf_cpu_mode_t cpu_mode = PSSF_PROGRAM;
  pssf_key_t keyswitch = PSSF_KEY_STOP;
  logic brk = 1'b0;
  logic ien = 1'b0;
  logic idis = 1'b0;
  logic fz = 1'b0;
  logic sel = 1'b0;
  logic [7:0] miss = 8'h00;
  logic [3:0] sw = 4'h0;
  pssf_scan_mode_t smode = PSSF_SCAN_VARIABLE;
  logic [15:0] slim = 16'h0002;
  logic oclr = 1'b0;
  logic cb = 1'b0;
  logic kb = 1'b0;
  logic chk = 1'b0;
  logic mism = 1'b0;
  logic fp, ct, cf, alt, b1, b2, ie, hold, bdis, ovr, low, cfg;
  pssf_timebase_t tb;
  pssf_mode_flags_t mf;
  pssf_switch_t swm;
  logic [7:0] slots;
  logic [15:0] code;
  int mismatches = 0;
  int n_compared = 0;

  typedef struct packed {
    pssf_key_t key; pssf_cpu_mode_t mode; logic [3:0] sw;
    logic cb, kb, fz, sel; logic [7:0] miss; logic [5:0] mf;
    logic low; logic [15:0] code; logic hold; logic [7:0] slots;
  } pssf_row_t;
  pssf_row_t rows [7];

  // Clock
  always #2 clk = ~clk;

  pssf_flags #(.TICK_CYCLES(TK), .MS_CYCLES(MS), .SLOTS(8)) dut_u (
    .clk(clk), .reset(reset), .scan_start(scan_start),
    .cpu_mode(cpu_mode), .keyswitch(keyswitch), .break_exec(brk),
    .interrupt_enable_instruction(ien), .interrupt_disable_exec(idis),
    .io_freeze_bit(fz), .selective_freeze_bit(sel),
    .block_missing(miss), .rear_switch(sw), .scan_mode(smode),
    .scan_limit_ms(slim), .overrun_clear(oclr),
    .cpu_battery_low(cb), .cart_battery_low(kb),
    .io_config_check_en(chk), .io_config_mismatch(mism),
    .first_pass_flag(fp), .constant_true_flag(ct),
    .constant_false_flag(cf), .alternating_pass_flag(alt),
    .timebase(tb), .mode_flags(mf), .break_flag_one(b1),
    .break_flag_two(b2), .interrupt_enabled_flag(ie),
    .io_update_hold(hold), .slot_output_hold(slots),
    .switch_mirror(swm), .cpu_battery_disabled_flag(bdis),
    .scan_overrun_flag(ovr), .low_battery_flag(low),
    .battery_error_code_word(code), .io_config_error_flag(cfg));

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle scan boundary pulse, then settle
  task automatic scan();
    scan_start = 1'b1;
    tick(1);
    scan_start = 1'b0;
    tick(2);
  endtask

  // Count falling edges while a timebase bit stays at one level
  task automatic hold_len(input int idx, input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (tb[idx] === lvl && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask

  // High and low phase lengths of one timebase bit
  task automatic phase(input int idx, input int half);
    int n;
    int lim;
    lim = 4 * half + 20;
    hold_len(idx, 1'b0, lim, n);
    hold_len(idx, 1'b1, lim, n);
    hold_len(idx, 1'b0, lim, n);
    check(16'(n), 16'(half));
    hold_len(idx, 1'b1, lim, n);
    check(16'(n), 16'(half));
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (80000) @(posedge clk);
    mismatches++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rows[0] = '{PSSF_KEY_RUN, PSSF_RUN, 4'h1, 0, 0, 0, 0, 8'ha5,
      6'h20, 0, BATT_CODE_NONE, 0, 8'h00};
    rows[1] = '{PSSF_KEY_TERM, PSSF_RUN, 4'h2, 1, 0, 1, 0, 8'ha5,
      6'h10, 1, BATT_CODE_CPU, 1, 8'hff};
    rows[2] = '{PSSF_KEY_TERM, PSSF_PROGRAM, 4'h4, 0, 1, 0, 1, 8'ha5,
      6'h08, 1, BATT_CODE_CART, 0, 8'ha5};
    rows[3] = '{PSSF_KEY_TERM, PSSF_TEST_RUN, 4'h8, 1, 1, 0, 1, 8'h3c,
      6'h04, 1, BATT_CODE_BOTH, 0, 8'h3c};
    rows[4] = '{PSSF_KEY_STOP, PSSF_TEST_PROGRAM, 4'hf, 0, 0, 0, 0,
      8'hff, 6'h03, 0, BATT_CODE_NONE, 0, 8'h00};
    rows[5] = '{PSSF_KEY_RUN, PSSF_PROGRAM, 4'h0, 0, 0, 0, 0, 8'h00,
      6'h20, 0, BATT_CODE_NONE, 0, 8'h00};
    rows[6] = '{PSSF_KEY_STOP, PSSF_RUN, 4'h0, 0, 0, 0, 0, 8'h00,
      6'h01, 0, BATT_CODE_NONE, 0, 8'h00};
    // Reset values
    tick(16);
    check(ct, 1'b1);
    check({fp, cf, alt, b1, b2, ie, ovr, low, cfg}, 9'h000);
    check(code, BATT_CODE_NONE);
    reset = 1'b0;
    tick(2);
    // First scan, then later scans
    scan();
    check({fp, alt}, 2'b11);
    scan();
    check({fp, alt}, 2'b00);
    scan();
    check({fp, alt}, 2'b01);
    // Level inputs through the table
    foreach (rows[i])
    begin
      keyswitch = rows[i].key;
      cpu_mode = rows[i].mode;
      sw = rows[i].sw;
      cb = rows[i].cb;
      kb = rows[i].kb;
      fz = rows[i].fz;
      sel = rows[i].sel;
      miss = rows[i].miss;
      tick(3);
      check(mf, rows[i].mf);
      check(swm, rows[i].sw);
      check(bdis, rows[i].sw[0]);
      check({low, code}, {rows[i].low, rows[i].code});
      check(hold, rows[i].hold);
      check(slots, rows[i].slots);
      check({ct, cf}, 2'b10);
    end
    // Re-arm on program to run; not on test modes
    cpu_mode = PSSF_PROGRAM;
    tick(3);
    cpu_mode = PSSF_RUN;
    tick(3);
    check(fp, 1'b0);
    scan();
    check(fp, 1'b1);
    scan();
    check(fp, 1'b0);
    cpu_mode = PSSF_TEST_RUN;
    tick(3);
    scan();
    check(fp, 1'b0);
    // Break flags
    brk = 1'b1;
    tick(1);
    brk = 1'b0;
    tick(2);
    check({b1, b2}, 2'b11);
    cpu_mode = PSSF_PROGRAM;
    tick(3);
    check({b1, b2}, 2'b01);
    cpu_mode = PSSF_TEST_PROGRAM;
    tick(3);
    check(b2, 1'b1);
    cpu_mode = PSSF_RUN;
    tick(3);
    check(b2, 1'b0);
    // Interrupt enable, disable, then both at once
    ien = 1'b1;
    tick(1);
    ien = 1'b0;
    tick(2);
    check(ie, 1'b1);
    idis = 1'b1;
    tick(1);
    idis = 1'b0;
    tick(2);
    check(ie, 1'b0);
    ien = 1'b1;
    idis = 1'b1;
    tick(1);
    {ien, idis} = 2'b00;
    tick(2);
    check(ie, 1'b1);
    // Configuration error gated by the check option
    mism = 1'b1;
    tick(1);
    mism = 1'b0;
    tick(2);
    check(cfg, 1'b0);
    chk = 1'b1;
    mism = 1'b1;
    tick(1);
    mism = 1'b0;
    tick(2);
    check(cfg, 1'b1);
    chk = 1'b0;
    tick(3);
    check(cfg, 1'b0);
    // Scan overrun in fixed and limit modes, never in variable
    for (int m = 0; m < 3; m++)
    begin
      smode = pssf_scan_mode_t'(m);
      scan();
      oclr = 1'b1;
      tick(1);
      oclr = 1'b0;
      tick(1);
      check(ovr, 1'b0);
      tick(30);
      check(ovr, (m != 0));
    end
    // Timebase square waves from the shared prescaler
    phase(0, TK);
    phase(1, 2 * TK);
    phase(2, 20 * TK);
    phase(3, 1200 * TK);
    test_done();
  end

endmodule
